// ### include/pll_regs_map.vh
// Register map, field positions, reset values and timing constants of the
// PLL mode control and status register bank. Definitions only.
`ifndef PLL_REGS_MAP_VH
`define PLL_REGS_MAP_VH

// Printed register indices (not all multiples of four: byte address = 4 * index)
`define IDX_REF_MODE_CTRL 8'h00
`define IDX_LOOP_STATUS 8'h01
`define IDX_CARRIER_CTRL 8'h04
`define IDX_IRQ_STATUS 8'h08
`define IDX_IRQ_ENABLE 8'h09
`define IDX_IRQ_CLEAR 8'h0A
`define ADDR_LSB 2
`define IDX_W 8

// reference_mode_control fields
`define BIT_REF_SEL 7
`define MODE_HI 4
`define MODE_LO 3
`define BIT_FILTER 2
`define BIT_REALIGN 0
`define REF_MODE_RST 8'h10
`define REF_MODE_WMASK 8'h9D

// loop_condition_status fields
`define BIT_LOCK 5
`define BIT_HOLDOVER 4
`define BIT_FREQUENCY_LIMIT_FLAG 2

// carrier_output_control fields
`define BIT_HIGH_RATE 7
`define BIT_CARRIER_RATE 6
`define CARRIER_RST 8'h00
`define CARRIER_WMASK 8'hC0

// Operating modes
`define MODE_NORMAL 2'h0
`define MODE_HOLDOVER 2'h1
`define MODE_FREERUN 2'h2

// Interrupt events: 0 lock change, 1 holdover entry, 2 frequency limit, 3 realign done
`define IRQ_W 4
`define IRQ_LOCK 0
`define IRQ_HOLD 1
`define IRQ_FREQUENCY_LIMIT_FLAG 2
`define IRQ_ALIGN 3

// Clock and realign phase slope (ns of phase per window)
`define CLK_NS 50
`define SLOPE_WIDE_NS 41
`define SLOPE_WIDE_WIN_NS 1326000
`define SLOPE_NARROW_NS 885
`define SLOPE_NARROW_WIN_NS 1000000000
// Phase step of one output-clock nudge, in ns
`define PHASE_STEP_NS 1
// Phase steps issued per realign
`define REALIGN_STEP_COUNT 64
// Longest holdover-entry latency (8 kHz reference), in ns
`define FAIL_DETECT_NS 130000

`endif

// ### hw/slope_limiter.v
// Rate limiter: emits a step pulse at most once per interval while enabled.
// Assumes hclk domain; interval chosen by caller from the filter corner.
`timescale 1ns/1ns
`default_nettype none
module slope_limiter #(
	parameter integer CNT_W = 24
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Control
	input wire enable,
	input wire [CNT_W-1:0] interval,
	// Step strobe
	output reg step
);
	reg [CNT_W-1:0] count_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_q <= {CNT_W{1'b0}};
			step <= 1'b0;
		end else if (!enable) begin
			count_q <= {CNT_W{1'b0}};
			step <= 1'b0;
		end else if (count_q >= interval - {{(CNT_W-1){1'b0}}, 1'b1}) begin
			count_q <= {CNT_W{1'b0}};
			step <= 1'b1;
		end else begin
			count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
			step <= 1'b0;
		end
	end
endmodule // slope_limiter
`default_nettype wire

// ### hw/pll_mode_regs.v
// AHB-Lite register bank for mode control and status of a clock PLL.
// Assumes a single AHB-Lite master on hclk; loop indications come from pins.
// Register index = byte address / 4; only bits [7:0] of a word are used.
`timescale 1ns/1ns
`default_nettype none
`include "pll_regs_map.vh"
module pll_mode_regs (
	// AHB-Lite slave
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// Loop indications from the PLL datapath (asynchronous)
	input wire core_locked_in,
	input wire primary_acq_holdover_in,
	input wire secondary_acq_holdover_in,
	input wire primary_ref_fail_in,
	input wire secondary_ref_fail_in,
	input wire freq_limit_in,
	input wire hardware_control_pin,
	// Controls to the PLL datapath
	output reg reference_source_select,
	output reg [1:0] core_mode,
	output reg filter_corner_select,
	output reg realign_to_reference,
	output reg phase_step,
	output reg differential_155m_output_en,
	output reg [1:0] carrier_clock_output_sel,
	// Status and interrupt
	output reg lock_status,
	output reg holdover_status,
	output reg frequency_limit_flag,
	output reg irq
);
	// -------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------
	// Cycles between single-ns phase nudges so the slope stays under the limit
	localparam integer WIDE_STEP_CYC =
		(`SLOPE_WIDE_WIN_NS * `PHASE_STEP_NS + `SLOPE_WIDE_NS * `CLK_NS - 1) /
		(`SLOPE_WIDE_NS * `CLK_NS);
	localparam integer NARROW_STEP_CYC =
		(`SLOPE_NARROW_WIN_NS * `PHASE_STEP_NS + `SLOPE_NARROW_NS * `CLK_NS - 1) /
		(`SLOPE_NARROW_NS * `CLK_NS);
	// Phase error nudged away per realign, in steps
	localparam integer REALIGN_STEPS = `REALIGN_STEP_COUNT;

	// -------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------
	// Only the second stage feeds logic, so a metastable first stage stays contained
	reg [6:0] sync1_q;
	reg [6:0] sync2_q;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= 7'h00;
			sync2_q <= 7'h00;
		end else begin
			sync1_q <= {hardware_control_pin, freq_limit_in, secondary_ref_fail_in,
				primary_ref_fail_in, secondary_acq_holdover_in,
				primary_acq_holdover_in, core_locked_in};
			sync2_q <= sync1_q;
		end
	end
	wire locked_s = sync2_q[0];
	wire pri_hold_s = sync2_q[1];
	wire sec_hold_s = sync2_q[2];
	wire pri_fail_s = sync2_q[3];
	wire sec_fail_s = sync2_q[4];
	wire frequency_limit_flag_s = sync2_q[5];
	wire hw_ctrl_s = sync2_q[6];

	// -------------------------------------------------------------
	// AHB-Lite address phase capture
	// -------------------------------------------------------------
	reg wr_pend_q;
	reg rd_pend_q;
	reg [`IDX_W-1:0] idx_q;
	// hsize is not decoded: every register is one aligned word
	wire take = hsel & hready & htrans[1];
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			idx_q <= {`IDX_W{1'b0}};
		end else begin
			wr_pend_q <= take & hwrite;
			rd_pend_q <= take & ~hwrite;
			if (take)
				idx_q <= haddr[`ADDR_LSB+`IDX_W-1:`ADDR_LSB];
		end
	end

	// -------------------------------------------------------------
	// Control registers
	// -------------------------------------------------------------
	reg [7:0] ref_mode_q;
	reg [7:0] carrier_q;
	reg [`IRQ_W-1:0] irq_en_q;
	wire wr_ref = wr_pend_q & (idx_q == `IDX_REF_MODE_CTRL);
	wire wr_car = wr_pend_q & (idx_q == `IDX_CARRIER_CTRL);
	wire wr_ien = wr_pend_q & (idx_q == `IDX_IRQ_ENABLE);
	wire wr_clr = wr_pend_q & (idx_q == `IDX_IRQ_CLEAR);
	// Reserved bits are masked as they are written, so they always read zero
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_mode_q <= `REF_MODE_RST;
		end else if (wr_ref) begin
			ref_mode_q <= hwdata[7:0] & `REF_MODE_WMASK;
		end
	end
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			carrier_q <= `CARRIER_RST;
		end else if (wr_car) begin
			carrier_q <= hwdata[7:0] & `CARRIER_WMASK;
		end
	end
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_en_q <= {`IRQ_W{1'b0}};
		end else if (wr_ien) begin
			irq_en_q <= hwdata[`IRQ_W-1:0];
		end
	end
	wire sw_ref_sel = ref_mode_q[`BIT_REF_SEL];
	wire [1:0] sw_mode = ref_mode_q[`MODE_HI:`MODE_LO];
	wire sw_filter = ref_mode_q[`BIT_FILTER];
	wire sw_align = ref_mode_q[`BIT_REALIGN];

	// -------------------------------------------------------------
	// Core mode control
	// -------------------------------------------------------------
	// Registers govern only while the hardware-control pin is low, save that sw_filter still sets
	// the step pace of a running realign; otherwise the held values stay in force so the datapath never sees a glitch.
	wire sw_ctrl = ~hw_ctrl_s;
	wire acq_hold = sw_ref_sel ? sec_hold_s : pri_hold_s;
	wire ref_fail = sw_ref_sel ? sec_fail_s : pri_fail_s;
	reg [1:0] mode_d;
	always @* begin
		case (sw_mode)
			`MODE_NORMAL: begin
				// A failed or holding reference drops the loop into holdover at once
				if (acq_hold | ref_fail)
					mode_d = `MODE_HOLDOVER;
				else
					mode_d = `MODE_NORMAL;
			end
			`MODE_HOLDOVER: mode_d = `MODE_HOLDOVER;
			`MODE_FREERUN: mode_d = `MODE_FREERUN;
			default: mode_d = core_mode; // Reserved code keeps current mode
		endcase
	end

	// -------------------------------------------------------------
	// Realignment
	// -------------------------------------------------------------
	reg align_prev_q;
	reg [6:0] steps_left_q;
	wire slope_step;
	wire [23:0] step_interval = sw_filter ? NARROW_STEP_CYC[23:0]
		: WIDE_STEP_CYC[23:0];
	wire align_fall = align_prev_q & ~sw_align;
	// A new fall while a realign runs restarts the step count; the step timer
	// keeps running, so the slope limit still holds across the restart.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			align_prev_q <= 1'b0;
			steps_left_q <= 7'h00;
		end else begin
			align_prev_q <= sw_align;
			if (align_fall & sw_ctrl)
				steps_left_q <= REALIGN_STEPS[6:0];
			else if (slope_step && steps_left_q != 7'h00)
				steps_left_q <= steps_left_q - 7'h01;
		end
	end

	slope_limiter #(
		.CNT_W(24)
	) u_slope (
		.hclk(hclk),
		.hresetn(hresetn),
		.enable(steps_left_q != 7'h00),
		.interval(step_interval),
		.step(slope_step)
	);

	// -------------------------------------------------------------
	// Datapath controls
	// -------------------------------------------------------------
	// Reset puts the loop in free-run with the 155 MHz outputs driven
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reference_source_select <= 1'b0;
			core_mode <= `MODE_FREERUN;
			filter_corner_select <= 1'b0;
			differential_155m_output_en <= 1'b1;
			carrier_clock_output_sel <= 2'h0;
		end else if (sw_ctrl) begin
			reference_source_select <= sw_ref_sel;
			core_mode <= mode_d;
			filter_corner_select <= sw_filter;
			differential_155m_output_en <= ~carrier_q[`BIT_HIGH_RATE];
			// {high_rate, rate}: 00 11.184, 01 8.592, 10 44.736, 11 34.368 MHz
			carrier_clock_output_sel <= {carrier_q[`BIT_HIGH_RATE],
				carrier_q[`BIT_CARRIER_RATE]};
		end
	end

	// -------------------------------------------------------------
	// Realign strobes and status
	// -------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			realign_to_reference <= 1'b0;
			phase_step <= 1'b0;
			lock_status <= 1'b0;
			holdover_status <= 1'b0;
			frequency_limit_flag <= 1'b0;
		end else begin
			realign_to_reference <= steps_left_q != 7'h00;
			phase_step <= slope_step & (steps_left_q != 7'h00);
			// Lock only counts while the loop tracks a reference
			lock_status <= locked_s & (core_mode == `MODE_NORMAL);
			holdover_status <= core_mode == `MODE_HOLDOVER;
			frequency_limit_flag <= frequency_limit_flag_s;
		end
	end

	// -------------------------------------------------------------
	// Interrupts
	// -------------------------------------------------------------
	// The flag follows the raw level, so a short toggle near the limit also
	// raises an event; software is expected to filter such glitches.
	reg lock_prev_q;
	reg hold_prev_q;
	reg frequency_limit_flag_prev_q;
	reg align_busy_prev_q;
	reg [`IRQ_W-1:0] irq_stat_q;
	wire [`IRQ_W-1:0] irq_ev;
	assign irq_ev[`IRQ_LOCK] = lock_status ^ lock_prev_q;
	assign irq_ev[`IRQ_HOLD] = holdover_status & ~hold_prev_q;
	assign irq_ev[`IRQ_FREQUENCY_LIMIT_FLAG] = frequency_limit_flag & ~frequency_limit_flag_prev_q;
	assign irq_ev[`IRQ_ALIGN] = align_busy_prev_q & ~realign_to_reference;
	// Write-one-to-clear; zero bits leave their flag alone
	wire [`IRQ_W-1:0] irq_clr = wr_clr ? hwdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_prev_q <= 1'b0;
			hold_prev_q <= 1'b0;
			frequency_limit_flag_prev_q <= 1'b0;
			align_busy_prev_q <= 1'b0;
		end else begin
			lock_prev_q <= lock_status;
			hold_prev_q <= holdover_status;
			frequency_limit_flag_prev_q <= frequency_limit_flag;
			align_busy_prev_q <= realign_to_reference;
		end
	end

	// Sticky status; irq is taken from the next status value so that it
	// rises together with the bit instead of a cycle behind it.
	wire [`IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_q <= {`IRQ_W{1'b0}};
			irq <= 1'b0;
		end else begin
			// New events win over a simultaneous clear
			irq_stat_q <= irq_stat_d;
			irq <= |(irq_stat_d & irq_en_q);
		end
	end

	// -------------------------------------------------------------
	// Read data
	// -------------------------------------------------------------
	reg [7:0] rd_d;
	always @* begin
		rd_d = 8'h00;
		case (idx_q)
			`IDX_REF_MODE_CTRL: rd_d = ref_mode_q;
			`IDX_LOOP_STATUS: begin
				rd_d[`BIT_LOCK] = lock_status;
				rd_d[`BIT_HOLDOVER] = holdover_status;
				rd_d[`BIT_FREQUENCY_LIMIT_FLAG] = frequency_limit_flag;
			end
			`IDX_CARRIER_CTRL: rd_d = carrier_q;
			`IDX_IRQ_STATUS: rd_d[`IRQ_W-1:0] = irq_stat_q;
			`IDX_IRQ_ENABLE: rd_d[`IRQ_W-1:0] = irq_en_q;
			default: rd_d = 8'h00;
		endcase
	end

	// -------------------------------------------------------------
	// Bus response
	// -------------------------------------------------------------
	// A read takes one wait state: the read register loads while the bus is
	// stalled, so hrdata stands at the edge that ends the data phase. Writes
	// need none, as they land at that same edge.
	wire rd_take = take & ~hwrite;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= ~rd_take;
			hresp <= 1'b0;
		end
	end

	// Read data holds until the next read so a slow master still sees it
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_pend_q) begin
			hrdata <= {24'h000000, rd_d};
		end
	end
endmodule // pll_mode_regs
`default_nettype wire

// ### sim/pll_mode_regs_monitor.sv
// Checker on the outputs of the PLL mode register bank.
// Assumes it is bound to pll_mode_regs and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module pll_mode_regs_monitor (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Pins and controls
	input wire primary_ref_fail_in,
	input wire hardware_control_pin,
	input wire reference_source_select,
	input wire [1:0] core_mode,
	input wire filter_corner_select,
	input wire realign_to_reference,
	input wire phase_step,
	input wire differential_155m_output_en,
	input wire [1:0] carrier_clock_output_sel,
	input wire lock_status,
	input wire holdover_status
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Cycles since the last phase nudge, saturating
	logic [15:0] gap_q;
	always @(posedge hclk or negedge hresetn)
		if (!hresetn) gap_q <= 16'hFFFF;
		else if (phase_step) gap_q <= 16'h0000;
		else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
	sequence s_fail_in_normal;
		$rose(primary_ref_fail_in) && core_mode == 2'h0 && !reference_source_select
			&& !hardware_control_pin;
	endsequence
	sequence s_realign_wide;
		$rose(realign_to_reference) && !filter_corner_select;
	endsequence
	property p_fail_holdover; s_fail_in_normal |-> ##[1:15] holdover_status; endproperty
	property p_realign_moves; s_realign_wide |-> ##[1:700] phase_step; endproperty
	property p_step_in_realign;
		phase_step |-> realign_to_reference || $past(realign_to_reference);
	endproperty
	property p_slope; phase_step |-> gap_q >= (filter_corner_select ? 16'h5846 : 16'h0286); endproperty
	property p_mode_legal; core_mode != 2'h3; endproperty
	property p_lock; lock_status |-> core_mode == 2'h0 || $past(core_mode) == 2'h0; endproperty
	property p_hold; $rose(core_mode == 2'h1) |-> ##[0:2] holdover_status; endproperty
	property p_diff; differential_155m_output_en != carrier_clock_output_sel[1]; endproperty
	a_fail_holdover: assert property (p_fail_holdover) else $error("late holdover");
	a_realign_moves: assert property (p_realign_moves) else $error("no step");
	a_step_in_realign: assert property (p_step_in_realign) else $error("stray step");
	a_slope: assert property (p_slope) else $error("phase slope too steep");
	a_mode_legal: assert property (p_mode_legal) else $error("reserved mode");
	a_lock: assert property (p_lock) else $error("lock outside normal");
	a_hold: assert property (p_hold) else $error("holdover flag missing");
	a_diff: assert property (p_diff) else $error("155M enable wrong");
endmodule // pll_mode_regs_monitor
`default_nettype wire

// ### sim/ahb_host.sv
// Host processor model: single-word AHB-Lite transfers to the register bank.
// Assumes hready is the bank's hreadyout; read data taken as hready ends the data phase.
`timescale 1ns/1ns
`default_nettype none
`include "pll_regs_map.vh"
module ahb_host (
	// Bus
	input wire hclk,
	input wire hready,
	input wire [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	task xfer(input logic [7:0] idx, input logic w, input logic [7:0] wd, output logic [7:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (!hready);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (!hready);
		rd = hrdata[7:0];
	endtask
	// Realign needs a one then a zero in the realign bit
	task realign(input logic [7:0] base);
		logic [7:0] d;
		xfer(`IDX_REF_MODE_CTRL, 1'b1, base | 8'h01, d);
		xfer(`IDX_REF_MODE_CTRL, 1'b1, base, d);
	endtask
endmodule // ahb_host
`default_nettype wire

// ### sim/pll_mode_control_status_regs_bench.sv
// Self-checking bench of the PLL mode register bank with a host model.
// Assumes a 20 MHz clock; the host waits on hready for every answer.
`timescale 1ns/1ns
`default_nettype none
`include "pll_regs_map.vh"
module pll_mode_control_status_regs_bench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic core_locked_in = 1'b0, primary_acq_holdover_in = 1'b0;
	logic secondary_acq_holdover_in = 1'b0, primary_ref_fail_in = 1'b0;
	logic secondary_ref_fail_in = 1'b0, freq_limit_in = 1'b0;
	logic hardware_control_pin = 1'b0;
	wire hsel, hwrite, hreadyout, hresp, reference_source_select, filter_corner_select;
	wire realign_to_reference, phase_step, differential_155m_output_en;
	wire lock_status, holdover_status, frequency_limit_flag, irq;
	wire [31:0] haddr, hwdata, hrdata;
	wire [1:0] htrans, core_mode, carrier_clock_output_sel;
	wire [2:0] hsize;
	wire hready = hreadyout;
	int errors = 0, checks_done = 0;
	pll_mode_regs dut (.*);
	ahb_host host (.*);
	initial forever #25 hclk = ~hclk;
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task rd(input logic [7:0] idx, input logic [7:0] e);
		logic [7:0] d;
		host.xfer(idx, 1'b0, 8'h00, d);
		chk("readback", d, e);
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] v);
		logic [7:0] d;
		host.xfer(idx, 1'b1, v, d);
		repeat (4) @(negedge hclk);
	endtask
	task t_modes;
		for (int m = 0; m < 3; m++) begin
			wr(`IDX_REF_MODE_CTRL, 8'(m << 3));
			chk("core_mode", core_mode, m);
			chk("holdover", holdover_status, m == 1);
		end
		wr(`IDX_REF_MODE_CTRL, 8'h18);
		chk("reserved mode", core_mode, 2'h2);
	endtask
	task t_ctrl;
		wr(`IDX_REF_MODE_CTRL, 8'hE2);
		rd(`IDX_REF_MODE_CTRL, 8'h80);
		chk("reference_source_select", reference_source_select, 1'b1);
		wr(`IDX_REF_MODE_CTRL, 8'hE6);
		rd(`IDX_REF_MODE_CTRL, 8'h84);
		chk("fcs", filter_corner_select, 1'b1);
		wr(`IDX_REF_MODE_CTRL, 8'h00);
		chk("fcs", filter_corner_select, 1'b0);
		wr(`IDX_LOOP_STATUS, 8'hFF);
		rd(`IDX_LOOP_STATUS, 8'h00);
	endtask
	task t_realign;
		int n;
		logic [7:0] d;
		n = 0;
		wr(`IDX_IRQ_ENABLE, 8'h08);
		host.realign(8'h00);
		for (int c = 0; c < 45000 && (c < 4 || realign_to_reference); c++) begin
			@(negedge hclk);
			if (phase_step) n++;
		end
		chk("steps", n, 64);
		repeat (4) @(negedge hclk);
		chk("irq", irq, 1'b1);
		host.xfer(`IDX_IRQ_STATUS, 1'b0, 8'h00, d);
		chk("done bit", d[3], 1'b1);
		wr(`IDX_IRQ_CLEAR, 8'h08);
		chk("irq masked", irq, 1'b0);
		wr(`IDX_IRQ_ENABLE, 8'h02);
		chk("irq", irq, 1'b1);
		wr(`IDX_IRQ_CLEAR, 8'h0F);
		chk("irq cleared", irq, 1'b0);
	endtask
	task t_fail;
		@(posedge hclk) core_locked_in <= 1'b1;
		@(posedge hclk) freq_limit_in <= 1'b1;
		repeat (5) @(negedge hclk);
		chk("lock", lock_status, 1'b1);
		chk("frequency_limit_flag", frequency_limit_flag, 1'b1);
		rd(`IDX_LOOP_STATUS, 8'h24);
		@(posedge hclk) primary_ref_fail_in <= 1'b1;
		repeat (15) @(negedge hclk);
		chk("holdover", holdover_status, 1'b1);
		rd(`IDX_LOOP_STATUS, 8'h14);
	endtask
	task t_carrier;
		for (int v = 0; v < 4; v++) begin
			wr(`IDX_CARRIER_CTRL, 8'(v << 6) | 8'h3F);
			rd(`IDX_CARRIER_CTRL, 8'(v << 6));
			chk("carrier", carrier_clock_output_sel, v);
			chk("155M en", differential_155m_output_en, v < 2);
		end
		rd(8'h02, 8'h00);
		@(posedge hclk) hardware_control_pin <= 1'b1;
		repeat (4) @(negedge hclk);
		wr(`IDX_CARRIER_CTRL, 8'h00);
		rd(`IDX_CARRIER_CTRL, 8'h00);
		chk("hw hold", carrier_clock_output_sel, 2'h3);
		chk("hw hold en", differential_155m_output_en, 1'b0);
		@(posedge hclk) hardware_control_pin <= 1'b0;
		repeat (5) @(negedge hclk);
		chk("sw ctrl", carrier_clock_output_sel, 2'h0);
		chk("sw ctrl en", differential_155m_output_en, 1'b1);
	endtask
	task final_report;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		chk("core_mode", core_mode, 2'h2);
		rd(`IDX_REF_MODE_CTRL, 8'h10);
		rd(`IDX_CARRIER_CTRL, 8'h00);
		t_modes();
		t_ctrl();
		t_realign();
		t_fail();
		t_carrier();
		final_report();
	end
	// Realign alone takes about 41.4k cycles
	initial begin
		#(60000 * 50);
		errors++;
		final_report();
	end
endmodule // pll_mode_control_status_regs_bench
bind pll_mode_regs pll_mode_regs_monitor mon (.hclk, .hresetn, .primary_ref_fail_in,
	.hardware_control_pin, .reference_source_select, .core_mode, .filter_corner_select,
	.realign_to_reference, .phase_step, .differential_155m_output_en,
	.carrier_clock_output_sel, .lock_status, .holdover_status);
`default_nettype wire
